// ===== pcil_pkg.sv
// ==========================================================================
// Shared constants for the port configuration image loader
// ==========================================================================
package pcil_pkg;

    // ======================================================================
    // Geometry
    // ======================================================================
    localparam int          PCIL_NREGS       = 8;        // Registers per port
    localparam int          PCIL_IDX_W       = 3;        // Register index width
    localparam int          PCIL_PADDR_W     = 13;       // APB address width

    // ======================================================================
    // Per-port register offsets (byte offset inside a 1 KB port window)
    // ======================================================================
    localparam logic [9:0]  PCIL_OFF_VGA     = 10'h070;  // VGA decode enable
    localparam logic [9:0]  PCIL_OFF_PMC     = 10'h074;  // PM control parameter
    localparam logic [9:0]  PCIL_OFF_VND     = 10'h088;  // Vendor control five
    localparam logic [9:0]  PCIL_OFF_TCM     = 10'h154;  // Traffic class map VC0
    localparam logic [9:0]  PCIL_OFF_PBD     = 10'h214;  // Power budgeting data
    localparam logic [9:0]  PCIL_OFF_PBC     = 10'h218;  // Power budget capability
    localparam logic [9:0]  PCIL_OFF_PNUM    = 10'h0CC;  // Logical port number
    localparam logic [9:0]  PCIL_OFF_LPV     = 10'h144;  // Low priority group count

    // Storage index of each register inside a port
    localparam logic [2:0]  PCIL_IDX_VGA     = 3'h0;
    localparam logic [2:0]  PCIL_IDX_PMC     = 3'h1;
    localparam logic [2:0]  PCIL_IDX_VND     = 3'h2;
    localparam logic [2:0]  PCIL_IDX_TCM     = 3'h3;
    localparam logic [2:0]  PCIL_IDX_PBD     = 3'h4;
    localparam logic [2:0]  PCIL_IDX_PBC     = 3'h5;
    localparam logic [2:0]  PCIL_IDX_PNUM    = 3'h6;
    localparam logic [2:0]  PCIL_IDX_LPV     = 3'h7;

    // Loader control window: paddr[12:10] selects it, low bits the word
    localparam logic [2:0]  PCIL_CTL_WIN     = 3'h6;
    localparam logic [9:0]  PCIL_OFF_CTRL    = 10'h000;  // Bit 0 load enable
    localparam logic [9:0]  PCIL_OFF_STAT    = 10'h004;  // Count and last address

    // ======================================================================
    // Image word addresses
    // ======================================================================
    localparam logic [7:0]  PCIL_IMG_PB_BASE = 8'h70;    // Power budget, port 0
    localparam logic [7:0]  PCIL_IMG_PM_BASE = 8'h80;    // Power management, port 0
    localparam logic [7:0]  PCIL_IMG_TC_P5   = 8'h6A;    // Port 5 map word
    localparam logic [7:0]  PCIL_IMG_STRIDE  = 8'h02;    // Words per port step
    localparam logic [2:0]  PCIL_TC_PORT     = 3'h5;     // Port owning the map word

    // ======================================================================
    // Reset values
    // ======================================================================
    localparam logic [31:0] PCIL_REG_RESET   = 32'h0000_0000;
    localparam logic        PCIL_LOAD_RESET  = 1'b1;     // Loader enabled at reset

    // Image word classes
    typedef enum logic [3:0]
    {
        PCIL_K_NONE = 4'h1,
        PCIL_K_PB   = 4'h2,
        PCIL_K_PM   = 4'h4,
        PCIL_K_TC   = 4'h8
    } pcil_kind_t;

endpackage

// ===== pcil_port_regs.sv
`timescale 1ns/100ps
// ==========================================================================
// One port's configuration registers, written by software and by images
// ==========================================================================
module pcil_port_regs
    import pcil_pkg::*;
(
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // Software write
    input  wire logic                          sw_we,
    input  wire logic [PCIL_IDX_W-1:0]         sw_idx,
    input  wire logic [31:0]                   sw_wdata,
    // Image field writes
    input  wire logic                          pb_we,
    input  wire logic                          pm_we,
    input  wire logic                          tc_we,
    input  wire logic [15:0]                   img_data,
    // Register contents
    output logic      [PCIL_NREGS-1:0][31:0]   regs_q
);

    // ======================================================================
    // State
    // ======================================================================
    typedef struct packed
    {
        logic [PCIL_NREGS-1:0][31:0] regs;  // All registers of the port
    } pcil_port_t;

    pcil_port_t st_q;                       // Registered state
    pcil_port_t st_d;                       // Next state

    // Software write first, image fields overlaid so the loader wins a tie
    always_comb
    begin
        st_d = st_q;
        if (sw_we)
        begin
            st_d.regs[sw_idx] = sw_wdata;
        end
        if (pb_we)
        begin
            st_d.regs[PCIL_IDX_PBD][7:0]   = img_data[7:0];    // [R1]
            st_d.regs[PCIL_IDX_PBD][9:8]   = img_data[9:8];    // [R2]
            st_d.regs[PCIL_IDX_PBD][14:13] = img_data[11:10];  // [R3]
            st_d.regs[PCIL_IDX_PBC][0]     = img_data[15];     // [R4]
        end
        if (pm_we)
        begin
            st_d.regs[PCIL_IDX_PMC][14]    = img_data[6];      // [R6]
            st_d.regs[PCIL_IDX_PMC][13:8]  = img_data[5:0];    // [R7]
            st_d.regs[PCIL_IDX_VGA][31]    = img_data[7];      // [R8]
            st_d.regs[PCIL_IDX_VND][31:24] = img_data[15:8];   // [R9]
        end
        if (tc_we)
        begin
            st_d.regs[PCIL_IDX_TCM][7:1]   = img_data[15:9];   // [R11]
            st_d.regs[PCIL_IDX_LPV][4]     = img_data[3];      // [R12]
            st_d.regs[PCIL_IDX_PNUM][26:24] = img_data[6:4];   // [R12]
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '{regs: {PCIL_NREGS{PCIL_REG_RESET}}};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign regs_q = st_q.regs;

endmodule // pcil_port_regs

// ===== pcil_loader.sv
`timescale 1ns/100ps
// ==========================================================================
// Port configuration image loader slice with APB register access
// ==========================================================================
// How it works
// R1: Power word bits 7:0 set base power
// R2: Power word bits 9:8 set data scale
// R3: Power word bits 11:10 set PM state 14:13
// R4: Power word bit 15 sets system allocated
// R5: Power words at 70h plus two per port
// R6: PM word bit 6 disables receive polarity
// R7: PM word bits 5:0 fill bits 13:8
// R8: PM word bit 7 enables VGA decode
// R9: PM word bits 15:8 fill vendor control
// R10: PM words at 80h plus two per port
// R11: Port 5 word bits 15:9 fill map
// R12: Same word sets channel group, port number
// R13: Only valid words write, other bits kept
module pcil_loader
    import pcil_pkg::*;
#(
    parameter int NPORTS = 6                         // Ports served
)
(
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [PCIL_PADDR_W-1:0]    paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Configuration image words
    input  wire logic                       img_valid,
    input  wire logic [7:0]                 img_addr,
    input  wire logic [15:0]                img_data
);

    // ======================================================================
    // Decode helpers
    // ======================================================================
    // Map a byte offset inside a port window to a storage index
    function automatic logic [PCIL_IDX_W:0] reg_lookup(input logic [9:0] off);
        logic [PCIL_IDX_W:0] r;
        r = '0;
        unique case (off)
            PCIL_OFF_VGA:  r = {1'b1, PCIL_IDX_VGA};
            PCIL_OFF_PMC:  r = {1'b1, PCIL_IDX_PMC};
            PCIL_OFF_VND:  r = {1'b1, PCIL_IDX_VND};
            PCIL_OFF_TCM:  r = {1'b1, PCIL_IDX_TCM};
            PCIL_OFF_PBD:  r = {1'b1, PCIL_IDX_PBD};
            PCIL_OFF_PBC:  r = {1'b1, PCIL_IDX_PBC};
            PCIL_OFF_PNUM: r = {1'b1, PCIL_IDX_PNUM};
            PCIL_OFF_LPV:  r = {1'b1, PCIL_IDX_LPV};
            default:       r = '0;
        endcase
        return r;
    endfunction

    // Classify an image word address; port number in the low bits
    function automatic logic [6:0] img_lookup(input logic [7:0] a);
        logic [7:0] pbo;
        logic [7:0] pmo;
        pbo = a - PCIL_IMG_PB_BASE;
        pmo = a - PCIL_IMG_PM_BASE;
        img_lookup = {PCIL_K_NONE, 3'h0};
        if (a == PCIL_IMG_TC_P5)
        begin
            img_lookup = {PCIL_K_TC, PCIL_TC_PORT};                   // [R11]
        end
        else if (!pbo[0] && pbo[7:1] < 7'(NPORTS))
        begin
            img_lookup = {PCIL_K_PB, pbo[3:1]};                       // [R5]
        end
        else if (!pmo[0] && pmo[7:1] < 7'(NPORTS))
        begin
            img_lookup = {PCIL_K_PM, pmo[3:1]};                       // [R10]
        end
    endfunction

    // ======================================================================
    // State
    // ======================================================================
    typedef struct packed
    {
        logic        load_en;    // Image words are applied while set
        logic [15:0] words;      // Image words applied since reset
        logic [7:0]  last_addr;  // Address of the last applied word
        logic [31:0] rdata;      // Read data captured in setup phase
        logic        err;        // Error captured in setup phase
    } pcil_state_t;

    pcil_state_t st_q;                                // Registered state
    pcil_state_t st_d;                                // Next state

    // ======================================================================
    // Image decode
    // ======================================================================
    logic [6:0]                       img_dec;        // Class and port
    logic [3:0]                       img_kind;       // Word class
    logic [2:0]                       img_port;       // Target port
    logic                             img_take;       // Word accepted
    logic [NPORTS-1:0]                pb_we;          // Power word strobes
    logic [NPORTS-1:0]                pm_we;          // PM word strobes
    logic [NPORTS-1:0]                tc_we;          // Map word strobes

    assign img_dec  = img_lookup(img_addr);
    assign img_kind = img_dec[6:3];
    assign img_port = img_dec[2:0];
    // A word acts only when valid, enabled and mapped to this slice
    assign img_take = img_valid && st_q.load_en && (img_kind != PCIL_K_NONE); // [R13]

    // ======================================================================
    // APB decode
    // ======================================================================
    logic [PCIL_IDX_W:0]              acc_hit;        // Hit flag and index
    logic [2:0]                       acc_win;        // Window number
    logic                             acc_port;       // Port window hit
    logic                             acc_ctl;        // Control word hit
    logic                             acc_ok;         // Mapped and aligned
    logic                             sw_wr;          // Mapped write in access phase
    logic [NPORTS-1:0][PCIL_NREGS-1:0][31:0] port_regs; // All port registers

    assign acc_hit  = reg_lookup(paddr[9:0]);
    assign acc_win  = paddr[12:10];
    assign acc_port = (acc_win < 3'(NPORTS)) && acc_hit[PCIL_IDX_W];
    assign acc_ctl  = (acc_win == PCIL_CTL_WIN)
                      && (paddr[9:0] == PCIL_OFF_CTRL || paddr[9:0] == PCIL_OFF_STAT);
    assign acc_ok   = acc_port || acc_ctl;
    assign sw_wr    = psel && penable && pwrite && acc_ok;

    // Zero-wait slave: data and error were captured in the setup phase
    assign pready  = psel && penable;
    assign prdata  = st_q.rdata;
    assign pslverr = psel && penable && st_q.err;

    // ======================================================================
    // Per-port register banks
    // ======================================================================
    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp++)
        begin : g_port
            // Strobes for this port
            assign pb_we[gp] = img_take && img_kind == PCIL_K_PB && img_port == 3'(gp);
            assign pm_we[gp] = img_take && img_kind == PCIL_K_PM && img_port == 3'(gp);
            assign tc_we[gp] = img_take && img_kind == PCIL_K_TC && img_port == 3'(gp);

            pcil_port_regs u_regs
            (
                .pclk     (pclk),
                .presetn  (presetn),
                .sw_we    (sw_wr && acc_port && acc_win == 3'(gp)),
                .sw_idx   (acc_hit[PCIL_IDX_W-1:0]),
                .sw_wdata (pwdata),
                .pb_we    (pb_we[gp]),
                .pm_we    (pm_we[gp]),
                .tc_we    (tc_we[gp]),
                .img_data (img_data),
                .regs_q   (port_regs[gp])
            );
        end
    endgenerate

    // ======================================================================
    // Control, status and read capture
    // ======================================================================
    always_comb
    begin
        st_d = st_q;
        // Load enable from software
        if (sw_wr && acc_ctl && paddr[9:0] == PCIL_OFF_CTRL)
        begin
            st_d.load_en = pwdata[0];
        end
        // Count and remember applied words
        if (img_take)
        begin
            st_d.words     = st_q.words + 16'h0001;
            st_d.last_addr = img_addr;
        end
        // Setup phase: capture read data and error
        if (psel && !penable)
        begin
            st_d.err   = !acc_ok;
            st_d.rdata = 32'h0000_0000;
            if (acc_port)
            begin
                st_d.rdata = port_regs[acc_win][acc_hit[PCIL_IDX_W-1:0]];
            end
            else if (acc_ctl && paddr[9:0] == PCIL_OFF_CTRL)
            begin
                st_d.rdata = {31'h0000_0000, st_q.load_en};
            end
            else if (acc_ctl)
            begin
                st_d.rdata = {8'h00, st_q.last_addr, st_q.words};
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '{load_en: PCIL_LOAD_RESET, words: 16'h0000, last_addr: 8'h00,
                      rdata: 32'h0000_0000, err: 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Image power word accepted, competing write not excluded
    sequence s_pb_word;
        img_take && img_kind == PCIL_K_PB;
    endsequence

    // Image PM word accepted
    sequence s_pm_word;
        img_take && img_kind == PCIL_K_PM;
    endsequence

    // APB setup followed by access
    sequence s_apb_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence

    a_pb_base_copy: assert property (s_pb_word |=> // [R1]
        port_regs[$past(img_port)][PCIL_IDX_PBD][7:0] == $past(img_data[7:0]))
        else $error("Base power not copied");

    a_pb_scale_copy: assert property (s_pb_word |=> // [R2]
        port_regs[$past(img_port)][PCIL_IDX_PBD][9:8] == $past(img_data[9:8]))
        else $error("Data scale not copied");

    a_pb_state_copy: assert property (s_pb_word |=> // [R3]
        port_regs[$past(img_port)][PCIL_IDX_PBD][14:13] == $past(img_data[11:10]))
        else $error("PM state not copied");

    a_pb_alloc_copy: assert property (s_pb_word |=> // [R4]
        port_regs[$past(img_port)][PCIL_IDX_PBC][0] == $past(img_data[15]))
        else $error("System allocated bit not copied");

    a_pb_addr_map: assert property (s_pb_word |-> // [R5]
        img_addr == PCIL_IMG_PB_BASE + {4'h0, img_port, 1'b0})
        else $error("Power word address mismatch");

    a_pm_polarity_copy: assert property (s_pm_word |=> // [R6]
        port_regs[$past(img_port)][PCIL_IDX_PMC][14] == $past(img_data[6]))
        else $error("Polarity disable not copied");

    a_pm_ctrl_copy: assert property (s_pm_word |=> // [R7]
        port_regs[$past(img_port)][PCIL_IDX_PMC][13:8] == $past(img_data[5:0]))
        else $error("PM control not copied");

    a_pm_vga_copy: assert property (s_pm_word |=> // [R8]
        port_regs[$past(img_port)][PCIL_IDX_VGA][31] == $past(img_data[7]))
        else $error("VGA enable not copied");

    a_pm_vendor_copy: assert property (s_pm_word |=> // [R9]
        port_regs[$past(img_port)][PCIL_IDX_VND][31:24] == $past(img_data[15:8]))
        else $error("Vendor control not copied");

    a_pm_addr_map: assert property (s_pm_word |-> // [R10]
        img_addr == PCIL_IMG_PM_BASE + {4'h0, img_port, 1'b0})
        else $error("PM word address mismatch");

    a_tc_map_copy: assert property (img_take && img_kind == PCIL_K_TC |=> // [R11]
        port_regs[PCIL_TC_PORT][PCIL_IDX_TCM][7:1] == $past(img_data[15:9]))
        else $error("Traffic class map not copied");

    a_tc_extra_copy: assert property (img_take && img_kind == PCIL_K_TC |=> // [R12]
        port_regs[PCIL_TC_PORT][PCIL_IDX_PNUM][26:24] == $past(img_data[6:4])
        && port_regs[PCIL_TC_PORT][PCIL_IDX_LPV][4] == $past(img_data[3]))
        else $error("Port number or group bit not copied");

    a_unmapped_kept: assert property ((s_pb_word and !sw_wr) |=> // [R13]
        port_regs[$past(img_port)][PCIL_IDX_PBD][12:10]
        == $past(port_regs[img_port][PCIL_IDX_PBD][12:10]))
        else $error("Unmapped bits changed by image");

    a_disabled_ignored: assert property (img_valid && !st_q.load_en |=> // [R13]
        $stable(st_q.words))
        else $error("Word applied while loading disabled");

    a_apb_ready_access: assert property (s_apb_setup_access |->
        pready && pslverr == !$past(acc_ok))
        else $error("APB answer wrong in access phase");

endmodule // pcil_loader

// ===== pcil_image_rom.sv
`timescale 1ns/100ps
// ==========================================================================
// Image memory model: streams queued words out, one word per cycle
// ==========================================================================
module pcil_image_rom
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Image word stream
    output logic              img_valid,
    output logic [7:0]        img_addr,
    output logic [15:0]       img_data
);
    logic [23:0] pend_q [$];  // Words waiting to go out

    // Queue one word for delivery
    function automatic void push(input logic [7:0] a, input logic [15:0] d);
        pend_q.push_back({a, d});
    endfunction

    // Back to back delivery; idle lines toggle so stale words never look held
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            img_valid <= 1'b0;
            img_addr  <= 8'h00;
            img_data  <= 16'h0000;
        end
        else if (pend_q.size() != 0)
        begin
            img_valid              <= 1'b1;
            {img_addr, img_data}   <= pend_q.pop_front();
        end
        else
        begin
            img_valid <= 1'b0;
            img_addr  <= ~img_addr;
            img_data  <= ~img_data;
        end
    end
endmodule // pcil_image_rom

// ===== port_config_image_loader_test.sv
`timescale 1ns/100ps
// ==========================================================================
// Bench: APB register checks around image loading
// ==========================================================================
module port_config_image_loader_test;
    import pcil_pkg::*;
    logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic                    img_valid;
    logic [PCIL_PADDR_W-1:0] paddr;
    logic [31:0]             pwdata, prdata, rd;
    logic [7:0]              img_addr;
    logic [15:0]             img_data, d;
    logic                    er;
    int                      miscompares = 0, samples_checked = 0, cycles = 0;
    localparam logic [31:0]  BG = 32'h5A5A_A5A5;   // Background value
    localparam logic [9:0]   OFFS [8] = '{10'h070, 10'h074, 10'h088, 10'h0CC,
                                          10'h144, 10'h154, 10'h214, 10'h218};

    pcil_loader #(.NPORTS(6)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .img_valid(img_valid),
        .img_addr(img_addr), .img_data(img_data));
    pcil_image_rom rom (.pclk(pclk), .presetn(presetn), .img_valid(img_valid),
        .img_addr(img_addr), .img_data(img_data));

    // ======================================================================
    // Clock and hang guard
    // ======================================================================
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; waits for pready, then takes data and error
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read a port register and compare
    task automatic rdchk(input int p, input logic [9:0] o, input logic [31:0] e,
                         input string nm);
        apb(1'b0, {3'(p), o}, 32'h0);
        chk(nm, e, rd);
        chk({nm, " error"}, 32'h0, {31'h0, er});
    endtask
    // Wait until the image model has sent everything
    task automatic flush();
        while (rom.pend_q.size() != 0) @(posedge pclk);
        repeat (2) @(posedge pclk);
    endtask
    function automatic logic [15:0] pat(input int p);
        return 16'h8E3B ^ (16'h4B97 * 16'(p));
    endfunction
    function automatic logic [31:0] e_pbd(input logic [15:0] v);
        return (BG & 32'hFFFF_9C00) | {17'h0, v[11:10], 3'h0, v[9:0]};
    endfunction

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(0, 10'h070, PCIL_REG_RESET, "reset value");
        apb(1'b0, 13'h1800, 32'h0);
        chk("load enable reset", {31'h0, PCIL_LOAD_RESET}, rd & 32'h1);
        for (int p = 0; p < 6; p++)
            for (int i = 0; i < 8; i++)
                apb(1'b1, {3'(p), OFFS[i]}, BG);
        // Power budget and PM words streamed back to back
        for (int p = 0; p < 6; p++)
        begin
            rom.push(8'h70 + 8'(2 * p), pat(p));
            rom.push(8'h80 + 8'(2 * p), ~pat(p));
        end
        rom.push(8'h6A, 16'hB35A);
        flush();
        for (int p = 0; p < 6; p++)
        begin
            d = pat(p);
            rdchk(p, 10'h214, e_pbd(d), "power data");
            rdchk(p, 10'h218, {BG[31:1], d[15]}, "power cap");
            d = ~pat(p);
            rdchk(p, 10'h074, {BG[31:15], d[6:0], BG[7:0]}, "pm control");
            rdchk(p, 10'h070, {d[7], BG[30:0]}, "vga decode");
            rdchk(p, 10'h088, {d[15:8], BG[23:0]}, "vendor control");
        end
        d = 16'hB35A;
        rdchk(5, 10'h154, {BG[31:8], d[15:9], BG[0]}, "tc map");
        rdchk(5, 10'h0CC, {BG[31:27], d[6:4], BG[23:0]}, "port number");
        rdchk(5, 10'h144, {BG[31:5], d[3], BG[3:0]}, "low priority group");
        rdchk(4, 10'h154, BG, "tc map port 4");
        // Words while loading is off, at an odd address, past the last port
        apb(1'b1, 13'h1800, 32'h0);
        rom.push(8'h70, 16'hFFFF);
        flush();
        apb(1'b1, 13'h1800, 32'h1);
        rom.push(8'h71, 16'hFFFF);
        rom.push(8'h7C, 16'hFFFF);
        flush();
        rdchk(0, 10'h214, e_pbd(pat(0)), "refused word");
        apb(1'b0, 13'h1804, 32'h0);
        chk("applied count", {8'h6A, 16'd13}, {8'h0, rd[23:0]});
        // Status is read-only: a write is ignored without an error
        apb(1'b1, 13'h1804, 32'hFFFF_FFFF);
        chk("status write error", 32'h0, {31'h0, er});
        apb(1'b0, 13'h1804, 32'h0);
        chk("status kept", {8'h6A, 16'd13}, {8'h0, rd[23:0]});
        // Unmapped register accesses
        apb(1'b0, 13'h1C00, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, 13'h0010, 32'hFFFF_FFFF);
        chk("unmapped write error", 32'h1, {31'h0, er});
        report_and_stop();
    end
endmodule // port_config_image_loader_test
